// ==== logic/rtc_defs.svh ====
// constants of the update-hold and supply-monitor block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// reference clock rate
`define REF_CLK_MHZ 200
// bus map
`define ADDR_W 13
`define CTRL_ADDR 13'h1ff8
`define MEM_WORDS 8184
// control register field positions
`define CTRL_WHOLD_BIT 7
`define CTRL_RHOLD_BIT 6
// delay from supply-fail warning to deselect
`define PF_DELAY_MIN_US 10
`define PF_DELAY_MAX_US 40
`define PF_DELAY_CYC (`PF_DELAY_MIN_US * `REF_CLK_MHZ)
`define PF_DELAY_MAX_CYC (`PF_DELAY_MAX_US * `REF_CLK_MHZ)
// one second of timebase
`define SEC_S 1
`define SEC_CYC (`SEC_S * `REF_CLK_MHZ * 1000000)
// recovery time after power-up
`define REC_US 100
`define REC_CYC (`REC_US * `REF_CLK_MHZ)
// counter reset values
`define TIME_RESET 56'h00_00_00_01_01_01_00

`endif

// ==== logic/rtc_pkg.sv ====
// types shared by the clock block
`default_nettype none
package rtc_pkg;
	// one time snapshot, bcd fields
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} time_s;

	// supply sequencing states
	typedef enum logic [3:0] {
		PS_UP = 4'h1,
		PS_RUN = 4'h2,
		PS_WARN = 4'h4,
		PS_DOWN = 4'h8
	} pwr_e;
endpackage : rtc_pkg
`default_nettype wire

// ==== logic/rtc_time_if.sv ====
// link between the register side and the running counters
`timescale 1ns/1ps
`default_nettype none
interface rtc_time_if;
	import rtc_pkg::*;
	logic tick;
	logic load;
	time_s ld;
	time_s cur;
	modport counter (input tick, input load, input ld, output cur);
	modport ctrl (output tick, output load, output ld, input cur);
endinterface : rtc_time_if
`default_nettype wire

// ==== logic/rtc_counter.sv ====
// real time counters, bcd, 24 hour, with leap years
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_counter
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// time link
	rtc_time_if.counter tm
);
	import rtc_pkg::*;

	time_s cur_ff;
	time_s nxt_cur;
	logic [7:0] date_max;
	logic leap;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// year mod 4 from bcd: ten is 2 mod 4
	assign leap = cur_ff.year[4] ? (cur_ff.year[3:0] == 4'h2 || cur_ff.year[3:0] == 4'h6)
		: (cur_ff.year[3:0] == 4'h0 || cur_ff.year[3:0] == 4'h4 || cur_ff.year[3:0] == 4'h8);

	// month length
	always_comb
	begin
		case (cur_ff.month)
			8'h02: date_max = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: date_max = 8'h30;
			default: date_max = 8'h31;
		endcase
	end

	// counters keep running whatever the register copy does
	always_comb
	begin
		nxt_cur = cur_ff;
		if (tm.load)
			nxt_cur = tm.ld;
		else if (tm.tick)
		begin
			nxt_cur.sec = bcd_inc(cur_ff.sec);
			if (cur_ff.sec == 8'h59)
			begin
				nxt_cur.sec = 8'h00;
				nxt_cur.min = bcd_inc(cur_ff.min);
				if (cur_ff.min == 8'h59)
				begin
					nxt_cur.min = 8'h00;
					nxt_cur.hour = bcd_inc(cur_ff.hour);
					if (cur_ff.hour == 8'h23)
					begin
						nxt_cur.hour = 8'h00;
						nxt_cur.day = (cur_ff.day == 8'h07) ? 8'h01 : bcd_inc(cur_ff.day);
						nxt_cur.date = bcd_inc(cur_ff.date);
						if (cur_ff.date >= date_max)
						begin
							nxt_cur.date = 8'h01;
							nxt_cur.month = bcd_inc(cur_ff.month);
							if (cur_ff.month >= 8'h12)
							begin
								nxt_cur.month = 8'h01;
								nxt_cur.year = (cur_ff.year == 8'h99) ? 8'h00
									: bcd_inc(cur_ff.year);
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			cur_ff <= `TIME_RESET;
		else
			cur_ff <= nxt_cur;
	end

	assign tm.cur = cur_ff;
endmodule : rtc_counter
`default_nettype wire

// ==== logic/rtc_hold_pf.sv ====
// byte-wide clock ram: update hold control and supply-fail handling
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_hold_pf
#(
	parameter int SEC_CYCLES = `SEC_CYC,
	parameter int REC_CYCLES = `REC_CYC
)
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// memory bus pins
	input wire logic i_select_active_low_n,
	input wire logic i_select_active_high,
	input wire logic i_write_en_n,
	input wire logic i_output_en_n,
	input wire logic [`ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	// supply comparators
	input wire logic i_supply_below_threshold,
	input wire logic i_supply_above_upper,
	// interrupt pin
	output logic o_power_fail_int_n
);
	import rtc_pkg::*;

	localparam int PF_MIN_C = `PF_DELAY_CYC;
	localparam int PF_MAX_C = `PF_DELAY_MAX_CYC;

	// pin synchronisers
	logic [26:0] sy1_ff;
	logic [26:0] sy2_ff;
	logic s_cel_n, s_ceh, s_we_n, s_oe_n, s_low, s_ok;
	logic [`ADDR_W-1:0] s_addr;
	logic [7:0] s_data;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			sy1_ff <= 27'h0;
			sy2_ff <= 27'h0;
		end
		else
		begin
			sy1_ff <= {i_select_active_low_n, i_select_active_high, i_write_en_n, i_output_en_n,
				i_supply_below_threshold, i_supply_above_upper, i_addr, i_data};
			sy2_ff <= sy1_ff;
		end
	end
	assign {s_cel_n, s_ceh, s_we_n, s_oe_n, s_low, s_ok, s_addr, s_data} = sy2_ff;

	// supply sequencing
	pwr_e pwr_ff, nxt_pwr;
	logic [31:0] pcnt_ff, nxt_pcnt;
	logic int_ff, nxt_int;
	logic prot, desel;

	always_comb
	begin
		nxt_pwr = pwr_ff;
		nxt_pcnt = pcnt_ff + 32'h1;
		case (pwr_ff)
			PS_UP:
			begin
				if (s_low || !s_ok)
					nxt_pcnt = 32'h0;
				else if (pcnt_ff >= 32'(REC_CYCLES - 1))
					nxt_pwr = PS_RUN;
			end
			PS_RUN:
			begin
				nxt_pcnt = 32'h0;
				if (s_low)
					nxt_pwr = PS_WARN;
			end
			PS_WARN:
			begin
				if (pcnt_ff >= 32'(PF_MIN_C - 1))
					nxt_pwr = PS_DOWN;
			end
			PS_DOWN:
			begin
				nxt_pcnt = 32'h0;
				if (s_ok && !s_low)
					nxt_pwr = PS_UP;
			end
			default:
			begin
				nxt_pwr = PS_UP;
				nxt_pcnt = 32'h0;
			end
		endcase
		// pin low from the first warning until the supply is back
		nxt_int = (nxt_pwr == PS_WARN) || (nxt_pwr == PS_DOWN);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			pwr_ff <= PS_UP;
			pcnt_ff <= 32'h0;
			int_ff <= 1'b0;
		end
		else
		begin
			pwr_ff <= nxt_pwr;
			pcnt_ff <= nxt_pcnt;
			int_ff <= nxt_int;
		end
	end
	// writes stop at once, reads only after the delay
	assign prot = (pwr_ff != PS_RUN);
	assign desel = (pwr_ff == PS_UP) || (pwr_ff == PS_DOWN);
	assign o_power_fail_int_n = ~int_ff;

	// write cycle tracking; commit at end of the cycle
	logic sel, wr_now, wr_act_ff, spoil_ff, nxt_spoil, commit, mem_we;
	logic [`ADDR_W-1:0] waddr_ff, nxt_waddr;
	logic [7:0] wdata_ff, nxt_wdata;
	logic [7:0] mem [0:`MEM_WORDS-1];

	assign sel = ~s_cel_n & s_ceh;
	assign wr_now = sel & ~s_we_n;

	always_comb
	begin
		nxt_waddr = wr_now ? s_addr : waddr_ff;
		nxt_wdata = wr_now ? s_data : wdata_ff;
		// a cycle touched by protection is dropped; only its own byte is at stake
		nxt_spoil = wr_now & ((wr_act_ff & spoil_ff) | prot);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			wr_act_ff <= 1'b0;
			spoil_ff <= 1'b0;
			waddr_ff <= 13'h0;
			wdata_ff <= 8'h0;
		end
		else
		begin
			wr_act_ff <= wr_now;
			spoil_ff <= nxt_spoil;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
		end
	end
	assign commit = wr_act_ff & ~wr_now & ~spoil_ff & ~prot;
	assign mem_we = commit & (waddr_ff < `CTRL_ADDR);

	// plain ram cells hold no reset
	always_ff @(posedge i_ref_clk)
	begin
		if (mem_we)
			mem[waddr_ff] <= wdata_ff;
	end

	// clock register copies, byte 0 is control
	logic [7:0][7:0] creg_ff, nxt_creg;
	logic [31:0] tcnt_ff, nxt_tcnt;
	logic pend_ff, nxt_pend, whold_ff, hold, load, copy, creg_wr;
	rtc_time_if tm ();

	assign hold = creg_ff[0][`CTRL_WHOLD_BIT] | creg_ff[0][`CTRL_RHOLD_BIT];
	assign load = whold_ff & ~creg_ff[0][`CTRL_WHOLD_BIT];
	// copy waits one cycle after a load so the counters hold the new values
	assign copy = pend_ff & ~hold & ~load;
	assign creg_wr = commit & (waddr_ff >= `CTRL_ADDR);
	assign tm.tick = (tcnt_ff == 32'(SEC_CYCLES - 1));
	assign tm.load = load;
	assign tm.ld = {creg_ff[1], creg_ff[2], creg_ff[3], creg_ff[4], creg_ff[5], creg_ff[6],
		creg_ff[7]};

	always_comb
	begin
		nxt_tcnt = tm.tick ? 32'h0 : tcnt_ff + 32'h1;
		nxt_creg = creg_ff;
		if (creg_wr)
			nxt_creg[waddr_ff[2:0]] = wdata_ff;
		// single-cycle refresh of every time byte at once
		if (copy)
			{nxt_creg[1], nxt_creg[2], nxt_creg[3], nxt_creg[4], nxt_creg[5], nxt_creg[6],
				nxt_creg[7]} = tm.cur;
		// a tick during a hold is remembered, so release copies at once
		nxt_pend = (pend_ff & ~copy) | tm.tick | load;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			tcnt_ff <= 32'h0;
			creg_ff <= {`TIME_RESET, 8'h00};
			pend_ff <= 1'b1;
			whold_ff <= 1'b0;
		end
		else
		begin
			tcnt_ff <= nxt_tcnt;
			creg_ff <= nxt_creg;
			pend_ff <= nxt_pend;
			whold_ff <= creg_ff[0][`CTRL_WHOLD_BIT];
		end
	end

	// counters run from the timebase regardless of holds
	rtc_counter u_counter (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.tm(tm.counter)
	);

	// read path
	logic [7:0] dout_ff, nxt_dout;
	logic doe_ff, nxt_doe;

	always_comb
	begin
		nxt_dout = (s_addr >= `CTRL_ADDR) ? creg_ff[s_addr[2:0]] : mem[s_addr];
		nxt_doe = sel & ~desel & ~s_oe_n & s_we_n;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			dout_ff <= 8'h0;
			doe_ff <= 1'b0;
		end
		else
		begin
			dout_ff <= nxt_dout;
			doe_ff <= nxt_doe;
		end
	end
	assign o_data = dout_ff;
	assign o_data_oe = doe_ff;

	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_int_on_fail;
		(pwr_ff == PS_RUN) && s_low |=> !o_power_fail_int_n && (pwr_ff == PS_WARN);
	endproperty
	a_int_on_fail: assert property (p_int_on_fail) else $error("no interrupt on supply fail");

	property p_no_early_desel;
		(pwr_ff == PS_WARN) && (pcnt_ff < 32'(PF_MIN_C - 1)) |=> (pwr_ff == PS_WARN);
	endproperty
	a_no_early_desel: assert property (p_no_early_desel) else $error("deselect too early");

	property p_desel_in_time;
		(pwr_ff == PS_WARN) |-> (pcnt_ff < 32'(PF_MAX_C));
	endproperty
	a_desel_in_time: assert property (p_desel_in_time) else $error("deselect too late");

	property p_no_write_protected;
		(mem_we || creg_wr) |-> (pwr_ff == PS_RUN);
	endproperty
	a_no_write_protected: assert property (p_no_write_protected)
		else $error("write while protected");

	property p_quiet_deselected;
		desel ##1 desel |-> !o_data_oe;
	endproperty
	a_quiet_deselected: assert property (p_quiet_deselected)
		else $error("bus driven deselected");

	property p_hold_freezes;
		hold && !creg_wr |=> $stable(creg_ff[7:1]);
	endproperty
	a_hold_freezes: assert property (p_hold_freezes) else $error("time changed under hold");

	property p_counter_runs;
		tm.tick && !load && hold |=> (tm.cur != $past(tm.cur));
	endproperty
	a_counter_runs: assert property (p_counter_runs) else $error("counters stopped by hold");

	property p_load_on_release;
		$fell(creg_ff[0][`CTRL_WHOLD_BIT]) |=> (tm.cur == $past(tm.ld));
	endproperty
	a_load_on_release: assert property (p_load_on_release)
		else $error("release did not load");

	property p_copy_all;
		copy |=> ({creg_ff[1], creg_ff[2], creg_ff[3], creg_ff[4], creg_ff[5], creg_ff[6],
			creg_ff[7]} == $past(tm.cur));
	endproperty
	a_copy_all: assert property (p_copy_all) else $error("copy not in one update");

	property p_resume;
		$fell(hold) && pend_ff |-> ##[0:3] !pend_ff;
	endproperty
	a_resume: assert property (p_resume) else $error("updates not resumed");

	c_power_cycle: cover property ((pwr_ff == PS_DOWN) ##[1:20] (pwr_ff == PS_RUN));
	c_read_hold: cover property (creg_ff[0][`CTRL_RHOLD_BIT] ##[1:50] copy);
	c_set_clock: cover property (load ##1 copy);
	c_spoiled_write: cover property (spoil_ff && wr_act_ff && !wr_now);
endmodule : rtc_hold_pf
`default_nettype wire

// ==== verification/rtc_host_model.sv ====
// host processor model driving the byte-wide memory pins
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_host_model
(
	// clock
	input wire logic i_ref_clk,
	// memory bus pins
	output logic o_sel_n,
	output logic o_sel,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [`ADDR_W-1:0] o_addr,
	output logic [7:0] o_wdata,
	// read side
	input wire logic [7:0] i_rdata,
	input wire logic i_rdata_oe
);
	// selects idle from time zero, so nothing is written while supply rises
	initial
	begin
		o_sel_n = 1'b1;
		o_sel = 1'b0;
		o_we_n = 1'b1;
		o_oe_n = 1'b1;
		o_addr = '0;
		o_wdata = 8'h00;
	end

	// pins move after a falling edge and hold six cycles, past the sync flops
	task automatic bus_on(input logic [`ADDR_W-1:0] a, input logic wr, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_addr = a;
		o_wdata = d;
		o_sel_n = 1'b0;
		o_sel = 1'b1;
		o_we_n = ~wr;
		o_oe_n = wr;
		repeat (6) @(negedge i_ref_clk);
	endtask : bus_on

	// release; idle gap longer than the three cycles the device needs
	task automatic bus_off();
		o_sel_n = 1'b1;
		o_sel = 1'b0;
		o_we_n = 1'b1;
		o_oe_n = 1'b1;
		o_wdata = ~o_wdata; // released lines never keep the last byte
		repeat (4) @(negedge i_ref_clk);
	endtask : bus_off

	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		bus_on(a, 1'b1, d);
		bus_off();
	endtask : wr

	// returns drive flag above the byte
	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [8:0] d);
		bus_on(a, 1'b0, 8'h00);
		d = {i_rdata_oe, i_rdata};
		bus_off();
	endtask : rd
endmodule : rtc_host_model
`default_nettype wire

// ==== verification/rtc_hold_pf_tb.sv ====
// self-checking bench for the update-hold and supply-fail block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_hold_pf_tb;
	import rtc_pkg::*;
	localparam int SEC_CYC = 20;
	localparam int REC_CYC = 8;
	localparam logic [12:0] CTRL = `CTRL_ADDR;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic below = 1'b0;
	logic upper = 1'b1;
	logic sel_n, sel, we_n, oe_n, rdata_oe, int_n;
	logic [12:0] addr;
	logic [7:0] wdata, rdata, s0;
	logic [8:0] rv;
	logic [7:0] mem [int];
	int num_errors = 0;
	int comparisons = 0;
	int seed = 59671;
	int ai, n;
	realtime t0;

	always #2.5 ref_clk = ~ref_clk;

	rtc_hold_pf #(.SEC_CYCLES(SEC_CYC), .REC_CYCLES(REC_CYC)) u_dut
	(
		.i_ref_clk(ref_clk), .i_rstn(rstn),
		.i_select_active_low_n(sel_n), .i_select_active_high(sel),
		.i_write_en_n(we_n), .i_output_en_n(oe_n), .i_addr(addr),
		.i_data(wdata), .o_data(rdata), .o_data_oe(rdata_oe),
		.i_supply_below_threshold(below), .i_supply_above_upper(upper),
		.o_power_fail_int_n(int_n)
	);

	rtc_host_model u_host
	(
		.i_ref_clk(ref_clk), .o_sel_n(sel_n), .o_sel(sel), .o_we_n(we_n),
		.o_oe_n(oe_n), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
		.i_rdata_oe(rdata_oe)
	);

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// a driven read must return the expected byte
	task automatic rd_chk(input string what, input logic [12:0] a, input logic [7:0] exp);
		u_host.rd(a, rv);
		check(what, rv, {1'b1, exp});
	endtask : rd_chk

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// cut a hang short well past the expected run length
	initial
	begin
		#100us;
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		repeat (12) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (14) @(negedge ref_clk);
		// random ram traffic, both array ends included
		for (int i = 0; i < 10; i++)
		begin
			ai = (i == 0) ? 0 : (i == 1) ? `MEM_WORDS - 1 : {$random(seed)} % `MEM_WORDS;
			mem[ai] = 8'($random(seed));
			u_host.wr(13'(ai), mem[ai]);
		end
		foreach (mem[k])
			rd_chk("ram", 13'(k), mem[k]);
		// control byte keeps low bits, read-hold set
		s0 = 8'h40 | (8'($random(seed)) & 8'h3f);
		u_host.wr(CTRL, s0);
		rd_chk("ctrl", CTRL, s0);
		// both holds, then write-hold dropped: still frozen
		u_host.wr(CTRL, 8'hc0);
		u_host.wr(CTRL, 8'h40);
		u_host.rd(13'h1ff9, rv);
		s0 = rv[7:0];
		repeat (60) @(negedge ref_clk);
		rd_chk("sec held", 13'h1ff9, s0);
		// load a time near midnight at the end of february
		u_host.wr(CTRL, 8'h80);
		u_host.wr(13'h1ffb, 8'h23);
		u_host.wr(13'h1ffa, 8'h59);
		u_host.wr(13'h1ff9, 8'h58);
		u_host.wr(13'h1ffd, 8'h28);
		u_host.wr(13'h1ffe, 8'h02);
		u_host.wr(13'h1fff, 8'h01);
		repeat (60) @(negedge ref_clk);
		rd_chk("sec wr hold", 13'h1ff9, 8'h58);
		u_host.wr(CTRL, 8'h00);
		u_host.wr(CTRL, 8'h40);
		rd_chk("min", 13'h1ffa, 8'h59);
		rd_chk("hour", 13'h1ffb, 8'h23);
		u_host.rd(13'h1ff9, rv);
		check("sec", 9'(rv[7:0] == 8'h58 || rv[7:0] == 8'h59), 9'h1);
		// five seconds running cross midnight into march
		u_host.wr(CTRL, 8'h00);
		repeat (5 * SEC_CYC) @(negedge ref_clk);
		u_host.wr(CTRL, 8'h40);
		rd_chk("hour", 13'h1ffb, 8'h00);
		rd_chk("date", 13'h1ffd, 8'h01);
		rd_chk("month", 13'h1ffe, 8'h03);
		u_host.wr(CTRL, 8'h00);
		// supply fail: interrupt, blocked write, delayed deselect
		mem[256] = 8'h5a;
		mem[257] = 8'h5a;
		u_host.wr(13'h0100, 8'h5a);
		u_host.wr(13'h0101, 8'h5a);
		below = 1'b1;
		upper = 1'b0;
		n = 0;
		while (int_n !== 1'b0 && n < 10)
		begin
			@(negedge ref_clk);
			n++;
		end
		check("int delay", 9'(n <= 4), 9'h1);
		t0 = $realtime;
		u_host.wr(13'h0100, 8'ha5);
		u_host.bus_on(13'h0101, 1'b0, 8'h00);
		n = 0;
		while (rdata_oe !== 1'b0 && n < 9000)
		begin
			@(negedge ref_clk);
			n++;
		end
		n = int'(($realtime - t0) / 5.0);
		check("deselect", 9'(n >= 2000 && n <= 8000), 9'h1);
		u_host.bus_off();
		// supply back; a stray write during recovery must be dropped
		below = 1'b0;
		upper = 1'b1;
		u_host.wr(13'h0101, 8'hc3);
		repeat (REC_CYC + 6) @(negedge ref_clk);
		check("int", 9'(int_n), 9'h1);
		rd_chk("fail addr", 13'h0100, mem[256]);
		rd_chk("other", 13'h0101, mem[257]);
		report_and_stop();
	end
endmodule : rtc_hold_pf_tb
`default_nettype wire
